/* File: hdl/imau_unit.v */
// Purpose: integer multiply-accumulate datapath with register writeback
// Assumes: decode stage supplies operand values, indices and condition result
// Notes: one issue per cycle, result registered one cycle after issue
// Notes: wide forms write both ports in the same cycle
//
// Function
// RL1 - Plain multiply writes low product word
// RL2 - Multiply-add writes low word of sum
// RL3 - Multiply-subtract writes addend minus product
// RL4 - Truncated results ignore operand signedness
// RL5 - Missing destination uses first factor register
// RL6 - Flag form sets N, Z only
// RL7 - Software: flag form low regs, unconditional
// RL8 - Software never names stack or program counter
// RL9 - Wide product split into high, low
// RL10 - Double accumulate adds both old words
// RL11 - Wide accumulate adds 64-bit destination pair
// RL12 - Software keeps wide destinations distinct
// RL13 - Wide forms leave condition flags alone
// RL14 - Selectors pick bottom or top halfword
// RL15 - Half product plus addend, others ignored
// RL16 - Word by half keeps top 32 bits
// RL17 - Suffix selects second factor halfword
// RL18 - Accumulate overflow sets saturation sticky flag
// RL19 - False condition changes nothing
// RL20 - Saturation flag only set, never cleared
`timescale 1ns/1ps
`default_nettype none
`include "imau_map.vh"
module imau_unit #(
	parameter DATA_W = 32,
	parameter IDX_W = 4
) (
	input wire clock,
	input wire arst_n,
	input wire issueValid,
	input wire [`IMAU_OP_W-1:0] opCode,
	input wire condPass,
	input wire setFlags,
	input wire destGiven,
	input wire firstHalfTop,
	input wire secondHalfTop,
	input wire [DATA_W-1:0] firstFactor,
	input wire [DATA_W-1:0] secondFactor,
	input wire [DATA_W-1:0] addendVal,
	input wire [DATA_W-1:0] destLowOld,
	input wire [DATA_W-1:0] destHighOld,
	input wire [IDX_W-1:0] destIdx,
	input wire [IDX_W-1:0] destHighIdx,
	input wire [IDX_W-1:0] firstFactorIdx,
	output reg wrLowEn,
	output reg [IDX_W-1:0] wrLowIdx,
	output reg [DATA_W-1:0] wrLowData,
	output reg wrHighEn,
	output reg [IDX_W-1:0] wrHighIdx,
	output reg [DATA_W-1:0] wrHighData,
	output reg nzUpdate,
	output reg negFlag,
	output reg zeroFlag,
	output reg satSet
);
	// Long path width follows the data width; halfword width comes from the map
	localparam WIDE_W = 2 * DATA_W;
	localparam HALF_W = `IMAU_HALF_W;

	// Sign-extends the chosen halfword so both multiply paths share it
	function [DATA_W-1:0] pickHalf;
		input [DATA_W-1:0] word;
		input top;
		begin
			if (top) begin
				pickHalf = {{HALF_W{word[`IMAU_SIGN_BIT]}}, word[`IMAU_HALF_HI]}; // RL14
			end else begin
				pickHalf = {{HALF_W{word[`IMAU_HALF_SIGN]}}, word[`IMAU_HALF_LO]}; // RL14
			end
		end
	endfunction

	// Signed overflow: like-signed operands give an unlike-signed sum
	function addOverflow;
		input [DATA_W-1:0] a;
		input [DATA_W-1:0] b;
		input [DATA_W-1:0] s;
		begin
			addOverflow = (a[`IMAU_SIGN_BIT] == b[`IMAU_SIGN_BIT]) && (s[`IMAU_SIGN_BIT] != a[`IMAU_SIGN_BIT]);
		end
	endfunction

	// Datapath intermediates, all combinational
	wire [WIDE_W-1:0] wideProd;
	wire [WIDE_W-1:0] wideDacc;
	wire [WIDE_W-1:0] wideAcc;
	wire [31:0] lowProd;
	wire [31:0] hxA;
	wire [31:0] hxB;
	wire [31:0] halfProd;
	wire [31:0] halfSum;
	wire [31:0] multHalf;
	wire signed [47:0] wordHalfProd;
	wire [31:0] wordHalfTop;
	wire [31:0] wordHalfSum;
	wire [IDX_W-1:0] plainDest;
	wire doIssue;

	assign doIssue = issueValid & condPass; // RL19
	// Unsigned long paths: zero-extend both words before the wide multiply
	assign wideProd = {`IMAU_ZERO_WORD, firstFactor} * {`IMAU_ZERO_WORD, secondFactor}; // RL9
	// Two 32-bit addends cannot carry out of 64 bits, so no overflow check
	assign wideDacc = wideProd + {`IMAU_ZERO_WORD, destHighOld} + {`IMAU_ZERO_WORD, destLowOld}; // RL10
	assign wideAcc = wideProd + {destHighOld, destLowOld}; // RL11
	assign lowProd = wideProd[`IMAU_WORD_LO]; // RL4
	// Both selected halfwords arrive sign-extended to a full word
	assign hxA = pickHalf(firstFactor, firstHalfTop);
	assign hxB = pickHalf(secondFactor, secondHalfTop);
	// 16x16 signed never overflows 32 bits
	assign halfProd = $signed(hxA) * $signed(hxB); // RL15
	assign halfSum = halfProd + addendVal; // RL15
	assign multHalf = pickHalf(secondFactor, secondHalfTop); // RL17
	// Bottom product bits are dropped; the sum wraps like the core adder
	assign wordHalfProd = $signed(firstFactor) * $signed(multHalf[`IMAU_HALF_LO]);
	assign wordHalfTop = wordHalfProd[`IMAU_PROD48_TOP]; // RL16
	assign wordHalfSum = wordHalfTop + addendVal; // RL16
	assign plainDest = destGiven ? destIdx : firstFactorIdx; // RL5

	// Next values of the registered outputs
	reg lowEnD;
	reg highEnD;
	reg [DATA_W-1:0] lowDataD;
	reg [DATA_W-1:0] highDataD;
	reg [IDX_W-1:0] lowIdxD;
	reg nzD;
	reg satD;

	// Enables are gated by the condition; data paths run every cycle
	always @* begin
		lowEnD = doIssue;
		highEnD = 1'b0;
		lowDataD = `IMAU_ZERO_WORD;
		highDataD = `IMAU_ZERO_WORD;
		lowIdxD = plainDest;
		nzD = 1'b0;
		satD = 1'b0;
		case (opCode)
			`IMAU_OP_PLAIN: begin
				lowDataD = lowProd; // RL1
				nzD = doIssue & setFlags; // RL6
			end
			`IMAU_OP_ADD: begin
				lowDataD = lowProd + addendVal; // RL2
			end
			`IMAU_OP_SUB: begin
				lowDataD = addendVal - lowProd; // RL3
			end
			`IMAU_OP_WIDE: begin
				// Wide forms never touch flags
				lowIdxD = destIdx;
				nzD = 1'b0; // RL13
				lowDataD = wideProd[`IMAU_WORD_LO]; // RL9
				highDataD = wideProd[`IMAU_WORD_HI]; // RL9
				highEnD = doIssue;
			end
			`IMAU_OP_WIDE_DACC: begin
				// High word goes to its own index, flags untouched
				lowIdxD = destIdx;
				nzD = 1'b0; // RL13
				lowDataD = wideDacc[`IMAU_WORD_LO]; // RL10
				highDataD = wideDacc[`IMAU_WORD_HI]; // RL10
				highEnD = doIssue;
			end
			`IMAU_OP_WIDE_ACC: begin
				// Destination pair is one 64-bit accumulator
				lowIdxD = destIdx;
				nzD = 1'b0; // RL13
				lowDataD = wideAcc[`IMAU_WORD_LO]; // RL11
				highDataD = wideAcc[`IMAU_WORD_HI]; // RL11
				highEnD = doIssue;
			end
			`IMAU_OP_HALF_ACC: begin
				// Product cannot overflow; only the accumulate step is watched
				lowDataD = halfSum; // RL15
				satD = doIssue & addOverflow(halfProd, addendVal, halfSum); // RL18
			end
			`IMAU_OP_WORD_HALF: begin
				// Overflow is judged on the kept top word plus addend
				lowDataD = wordHalfSum; // RL16
				satD = doIssue & addOverflow(wordHalfTop, addendVal, wordHalfSum); // RL18
			end
			default: begin
				// Unused codes write nothing
				lowEnD = 1'b0;
			end
		endcase
	end

	// Registered outputs give the writeback port clean values
	always @(posedge clock or negedge arst_n) begin
		// Reset loads constants only
		if (!arst_n) begin
			wrLowEn <= 1'b0;
			wrLowIdx <= `IMAU_ZERO_IDX;
			wrLowData <= `IMAU_ZERO_WORD;
			wrHighEn <= 1'b0;
			wrHighIdx <= `IMAU_ZERO_IDX;
			wrHighData <= `IMAU_ZERO_WORD;
			nzUpdate <= 1'b0;
			negFlag <= 1'b0;
			zeroFlag <= 1'b0;
			satSet <= 1'b0;
		end else begin
			// Index and data follow even when idle; only the enables qualify a write
			wrLowEn <= lowEnD; // RL19
			wrLowIdx <= lowIdxD;
			wrLowData <= lowDataD;
			wrHighEn <= highEnD;
			wrHighIdx <= destHighIdx;
			wrHighData <= highDataD;
			nzUpdate <= nzD; // RL6
			negFlag <= lowDataD[`IMAU_SIGN_BIT]; // RL6
			zeroFlag <= (lowDataD == `IMAU_ZERO_WORD); // RL6
			// Pulse only: the status word holder ORs it in and clears it only on reset
			satSet <= satD; // RL20
		end
	end
endmodule // imau_unit
`default_nettype wire

/* File: hdl/imau_map.vh */
// Purpose: constants for the integer multiply-accumulate unit
// Assumes: 32-bit data path, 4-bit register indices
// Notes: operation codes are one-hot free binary codes on opCode
`ifndef IMAU_MAP_VH
`define IMAU_MAP_VH
`define IMAU_OP_W 3
`define IMAU_OP_PLAIN 3'h0
`define IMAU_OP_ADD 3'h1
`define IMAU_OP_SUB 3'h2
`define IMAU_OP_WIDE 3'h3
`define IMAU_OP_WIDE_DACC 3'h4
`define IMAU_OP_WIDE_ACC 3'h5
`define IMAU_OP_HALF_ACC 3'h6
`define IMAU_OP_WORD_HALF 3'h7
`define IMAU_HALF_LO 15:0
`define IMAU_HALF_HI 31:16
`define IMAU_HALF_W 16
`define IMAU_HALF_SIGN 15
`define IMAU_WORD_LO 31:0
`define IMAU_WORD_HI 63:32
`define IMAU_PROD48_TOP 47:16
`define IMAU_SIGN_BIT 31
`define IMAU_ZERO_WORD 32'h0000_0000
`define IMAU_ZERO_IDX 4'h0
`endif

/* File: tb/imau_psw.sv */
// Purpose: status word holder beside the unit
// Assumes: unit pulses are applied at the next edge
// Notes: no clear path, so the sticky bit stays set until reset
`timescale 1ns/1ps
`default_nettype none
module imau_psw (
	input wire logic clock, arst_n, nzUpdate, negFlag, zeroFlag, satSet,
	output logic nFlag, zFlag, satSticky
);
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) {nFlag, zFlag, satSticky} <= 3'h0;
		else begin
			if (nzUpdate) {nFlag, zFlag} <= {negFlag, zeroFlag};
			satSticky <= satSticky | satSet;
		end
	end
endmodule // imau_psw
`default_nettype wire

/* File: tb/imau_monitor.sv */
// Purpose: port checks of the multiply unit
// Assumes: one clock, async low reset
// Notes: results land one edge after issue
`timescale 1ns/1ps
`default_nettype none
`include "imau_map.vh"
module imau_monitor (
	input wire logic clock, arst_n, issueValid, condPass, setFlags, destGiven,
	input wire logic [`IMAU_OP_W-1:0] opCode,
	input wire logic [31:0] firstFactor, secondFactor, addendVal, wrLowData,
	input wire logic [3:0] firstFactorIdx, wrLowIdx,
	input wire logic wrLowEn, wrHighEn, nzUpdate, negFlag, zeroFlag, satSet
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	wire go = issueValid && condPass;
	wire [31:0] pr = firstFactor * secondFactor;
	quiet_cond_a: assert property (!go |=> !(wrLowEn | wrHighEn | nzUpdate | satSet))
		else $error("write without issue");
	low_write_a: assert property (go |=> wrLowEn) else $error("no write");
	plain_word_a: assert property (go && opCode == 0 |=> wrLowData == $past(pr))
		else $error("plain result");
	add_word_a: assert property (go && opCode == 1 |=> wrLowData == $past(pr) + $past(addendVal))
		else $error("add result");
	sub_word_a: assert property (go && opCode == 2 |=> wrLowData == $past(addendVal) - $past(pr))
		else $error("sub result");
	wide_pair_a: assert property (go && opCode inside {3, 4, 5} |=> wrHighEn && !nzUpdate)
		else $error("wide pair");
	dest_fallback_a: assert property (go && !destGiven && opCode < 3 |=> wrLowIdx == $past(firstFactorIdx))
		else $error("dest index");
	flag_form_a: assert property (go && opCode == 0 && setFlags |=> nzUpdate && negFlag == wrLowData[31]
		&& zeroFlag == (wrLowData == 0)) else $error("flag form");
	sat_source_a: assert property (satSet |-> $past(go) && $past(opCode) inside {6, 7})
		else $error("saturation without halfword accumulate");
endmodule // imau_monitor
bind imau_unit imau_monitor mon (.*);
`default_nettype wire

/* File: tb/imau_unit_bench.sv */
// Purpose: directed bench for the multiply unit
// Assumes: results read one edge after issue
// Notes: stimulus keeps low regs and distinct wide destinations
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module imau_unit_bench;
	logic clock = 0, arst_n = 0, issueValid = 0, condPass = 1, setFlags = 0, destGiven = 1;
	logic firstHalfTop = 0, secondHalfTop = 0;
	logic [2:0] opCode = 0;
	logic [31:0] firstFactor = 0, secondFactor = 0, addendVal = 0, destLowOld = 0, destHighOld = 0;
	logic [3:0] destIdx = 4'h1, destHighIdx = 4'h2, firstFactorIdx = 4'h3;
	logic [63:0] w;
	logic signed [47:0] p;
	logic signed [31:0] e32;
	wire wrLowEn, wrHighEn, nzUpdate, negFlag, zeroFlag, satSet, nFlag, zFlag, satSticky;
	wire [3:0] wrLowIdx, wrHighIdx;
	wire [31:0] wrLowData, wrHighData;
	int n_mismatch = 0, total_checks = 0, i;
	imau_unit DUT (.*);
	imau_psw PSW (.*);
	initial forever #25 clock = ~clock;
	task automatic iss(input [2:0] op, input [31:0] a, b, c);
		opCode = op; firstFactor = a; secondFactor = b; addendVal = c; issueValid = 1;
		@(posedge clock); #1;
	endtask
	task idle(input string s);
		issueValid = 0; @(posedge clock); #1 $display("%s done", s);
	endtask
	task t_plain;
		setFlags = 1; iss(0, 3, 5, 0); `CHK({wrLowData, nzUpdate, negFlag, zeroFlag}, {32'hF, 3'h4})
		iss(0, 32'hFFFF_FFFF, 2, 0); `CHK({wrLowData, negFlag, zeroFlag}, {32'hFFFF_FFFE, 2'h2})
		iss(0, 0, 7, 0); `CHK({negFlag, zeroFlag}, 2'h1)
		setFlags = 0; destGiven = 0; iss(0, 2, 2, 0); `CHK({wrLowIdx, nzUpdate}, {4'h3, 1'b0})
		destGiven = 1; idle("plain");
	endtask
	task t_acc;
		iss(1, 7, 9, 5); `CHK(wrLowData, 32'h44)
		iss(2, 7, 9, 5); `CHK(wrLowData, 32'hFFFF_FFC6)
		idle("accumulate");
	endtask
	task t_wide;
		destLowOld = 32'hFFFF_FFFF; destHighOld = 32'hFFFF_FFFF;
		for (i = 3; i < 6; i++) begin
			iss(i[2:0], 32'hFFFF_FFFF, 32'hFFFF_FFFE, 0);
			w = 64'hFFFF_FFFF * 64'hFFFF_FFFE + (i == 4 ? 64'h1_FFFF_FFFE : i == 5 ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0);
			`CHK({wrHighData, wrLowData, wrHighIdx, wrLowIdx}, {w, 8'h21})
			`CHK({wrHighEn, nzUpdate}, 2'h2)
		end
		idle("wide");
	endtask
	task t_half;
		for (i = 0; i < 4; i++) begin
			firstHalfTop = i[1]; secondHalfTop = i[0]; iss(6, 32'h8000_0003, 32'h0002_FFFF, 1);
			e32 = $signed(i[1] ? 16'h8000 : 16'h3) * $signed(i[0] ? 16'h2 : 16'hFFFF) + 32'sh1;
			`CHK(wrLowData, e32)
		end
		firstHalfTop = 0; secondHalfTop = 0; iss(6, 32'h4000, 32'h4000, 32'h7FFF_FFFF);
		`CHK(satSet, 1'b1)
		iss(6, 32'h4000, 32'h4000, 0); `CHK({satSet, satSticky}, 2'h1)
		for (i = 0; i < 2; i++) begin
			secondHalfTop = i[0]; iss(7, 32'h8000_0001, 32'h7FFF_8000, 32'h10);
			p = $signed(32'h8000_0001) * $signed(i[0] ? 16'h7FFF : 16'h8000);
			`CHK(wrLowData, p[47:16] + 32'h10)
		end
		idle("halfword");
	endtask
	task t_cond;
		condPass = 0; iss(1, 1, 1, 1); iss(5, 1, 1, 1);
		`CHK({wrLowEn, wrHighEn, nzUpdate, satSet}, 4'h0)
		condPass = 1; idle("condition");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clock);
		#1 arst_n = 1;
		t_plain; t_acc; t_wide; t_half; t_cond;
		final_report;
	end
	initial begin
		#20000 n_mismatch++;
		final_report;
	end
endmodule // imau_unit_bench
`default_nettype wire
